// *** logic/rlc_regs.svh ***
// Register offsets, field positions and reset values of the ladder control
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH
`define RLC_ADDR_W 4
`define RLC_CTRL_OFF 4'h0
`define RLC_STAT_OFF 4'h1
`define RLC_CTRL_RST 8'h00
`define RLC_EN_BIT 7
`define RLC_OE_BIT 6
`define RLC_RNG_BIT 5
`define RLC_SRC_BIT 4
`define RLC_TAP_HI 3
`define RLC_TAP_LO 0
`define RLC_TAP_MAX 4'hF
`endif

// *** logic/rlc_pkg.sv ***
// Types shared by the ladder control modules
package rlc_pkg;
    // Decoded control fields
    typedef struct packed {
        logic power;
        logic pin_oe;
        logic range_low;
        logic src_ext;
        logic [3:0] tap;
    } rlc_ctrl_t;
endpackage

// *** logic/rlc_ctrl_if.sv ***
// Interface carrying decoded control fields to the tap decoder
`timescale 1ns/1ps
`default_nettype none
interface rlc_ctrl_if;
    import rlc_pkg::*;
    rlc_ctrl_t ctrl;
    logic [15:0] tap_low;
    logic [15:0] tap_high;
    modport src (output ctrl, input tap_low, input tap_high);
    modport dec (input ctrl, output tap_low, output tap_high);
endinterface
`default_nettype wire

// *** logic/rlc_tap_decoder.sv ***
// One-hot tap decoder for both ladder segments
`timescale 1ns/1ps
`default_nettype none
module rlc_tap_decoder
    import rlc_pkg::*;
(
    rlc_ctrl_if.dec ctl
);
    // One select line per tap, gated by power and range
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_tap
            assign ctl.tap_low[i] = ctl.ctrl.power && ctl.ctrl.range_low
                && (ctl.ctrl.tap == 4'(i));
            assign ctl.tap_high[i] = ctl.ctrl.power && !ctl.ctrl.range_low
                && (ctl.ctrl.tap == 4'(i));
        end
    endgenerate
endmodule
`default_nettype wire

// *** logic/rlc_top.sv ***
// Reference ladder control register and pin steering
//
// Overview of operation
// - Bit 7 powers the ladder up
// - Bit 6 routes level to shared pin
// - Pin enable overrides port F direction
// - Range bit picks low or high taps
// - Source bit picks external or supply rails
// - Low four bits hold tap code
// - Reset clears the control register
// - Sleep wake keeps register contents
// - Works regardless of comparator mode
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
module rlc_top
    import rlc_pkg::*;
(
    // Clock and synchronous reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port, reads answered next cycle
    input wire logic [`RLC_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Port F latch and direction of the shared pin
    input wire logic port_f_direction_i,
    input wire logic port_f_data_i,
    // Controls toward the analog ladder
    output logic ladder_power_enable_o,
    output logic ladder_source_select_o,
    output logic [15:0] tap_low_sel_o,
    output logic [15:0] tap_high_sel_o,
    // Shared pin steering
    output logic ladder_pin_output_enable_o,
    output logic shared_reference_pin_oe_o,
    output logic shared_reference_pin_o
);
    // All module state
    // Ctrl is the software register, rdata the one-cycle read stage
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rdata;
    } rlc_state_t;

    rlc_state_t st_q; // Registered state
    rlc_state_t st_d; // Next state
    rlc_ctrl_if cif (); // Decoder link

    // Next state: register writes and read data
    // Reads never stall; their data stand for exactly one cycle
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = 8'h00;
        // Control register write, all eight bits
        if (wr_i && addr_i == `RLC_CTRL_OFF)
        begin
            st_d.ctrl = wdata_i;
        end
        // Read returns the addressed register, unmapped as zero
        if (rd_i)
        begin
            case (addr_i)
                `RLC_CTRL_OFF: st_d.rdata = st_q.ctrl;
                `RLC_STAT_OFF: st_d.rdata = {6'h00,
                    shared_reference_pin_oe_o, port_f_data_i};
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; no sleep input, so contents survive wake
    // Synchronous reset wins over a write in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '{ctrl: `RLC_CTRL_RST, rdata: 8'h00};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Field split of the control register
    // no comparator mode input
    always_comb
    begin
        cif.ctrl.power = st_q.ctrl[`RLC_EN_BIT];
        cif.ctrl.pin_oe = st_q.ctrl[`RLC_OE_BIT];
        cif.ctrl.range_low = st_q.ctrl[`RLC_RNG_BIT];
        cif.ctrl.src_ext = st_q.ctrl[`RLC_SRC_BIT];
        cif.ctrl.tap = st_q.ctrl[`RLC_TAP_HI:`RLC_TAP_LO];
    end

    // Tap decoder
    rlc_tap_decoder u_dec (
        .ctl(cif.dec)
    );

    // Outputs: read data, analog ladder controls and shared pin steering
    // Pin switch is not gated by power, so software can park the
    // pin in analog mode before the ladder is powered up
    assign rdata_o = st_q.rdata;
    assign ladder_power_enable_o = cif.ctrl.power;
    assign ladder_source_select_o = cif.ctrl.power && cif.ctrl.src_ext;
    assign tap_low_sel_o = cif.tap_low;
    assign tap_high_sel_o = cif.tap_high;
    assign ladder_pin_output_enable_o = cif.ctrl.pin_oe;
    assign shared_reference_pin_oe_o = !cif.ctrl.pin_oe
        && !port_f_direction_i;
    assign shared_reference_pin_o = port_f_data_i;

    // Checks on registered state and driven outputs
    // Reset check always runs; the others sleep while reset is held
    // Expected one-hot tap, worked out from the raw code field
    logic [15:0] chk_onehot; // Reference tap pattern for the checks
    assign chk_onehot = 16'h0001 << st_q.ctrl[`RLC_TAP_HI:`RLC_TAP_LO];

    reset_clears_a:
        assert property (@(posedge ref_clk_i)
            rst_i |=> st_q.ctrl == `RLC_CTRL_RST)
        else $error("control not cleared by reset");
    write_lands_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            wr_i && addr_i == `RLC_CTRL_OFF |=>
            ladder_power_enable_o == $past(wdata_i[`RLC_EN_BIT]))
        else $error("power bit not written");
    pin_route_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            ladder_pin_output_enable_o == st_q.ctrl[`RLC_OE_BIT])
        else $error("pin route wrong");
    oe_override_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            st_q.ctrl[`RLC_OE_BIT] |-> !shared_reference_pin_oe_o)
        else $error("digital driver not overridden");
    drv_enable_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            !st_q.ctrl[`RLC_OE_BIT] && !port_f_direction_i
            |-> shared_reference_pin_oe_o)
        else $error("digital driver not enabled");
    input_mode_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            port_f_direction_i |-> !shared_reference_pin_oe_o)
        else $error("digital driver on for input pin");
    pin_level_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            shared_reference_pin_o == port_f_data_i)
        else $error("digital pin level wrong");
    range_low_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            st_q.ctrl[`RLC_EN_BIT] && st_q.ctrl[`RLC_RNG_BIT]
            |-> tap_high_sel_o == 16'h0000 && tap_low_sel_o == chk_onehot)
        else $error("low range decode wrong");
    source_sel_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            st_q.ctrl[`RLC_EN_BIT] |->
            ladder_source_select_o == st_q.ctrl[`RLC_SRC_BIT])
        else $error("source select wrong");
    tap_high_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            st_q.ctrl[`RLC_EN_BIT] && !st_q.ctrl[`RLC_RNG_BIT]
            |-> tap_high_sel_o == chk_onehot && tap_low_sel_o == 16'h0000)
        else $error("high range decode wrong");
    hold_value_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            !(wr_i && addr_i == `RLC_CTRL_OFF) |=> $stable(st_q.ctrl))
        else $error("control changed without write");
    idle_off_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            !st_q.ctrl[`RLC_EN_BIT] |-> tap_low_sel_o == 16'h0000
            && tap_high_sel_o == 16'h0000 && !ladder_source_select_o)
        else $error("ladder active while disabled");
    read_back_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            rd_i && addr_i == `RLC_CTRL_OFF && !wr_i |=>
            rdata_o == $past(st_q.ctrl))
        else $error("read data wrong");
    status_read_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            rd_i && addr_i == `RLC_STAT_OFF |=>
            rdata_o == {6'h00, $past(shared_reference_pin_oe_o),
            $past(port_f_data_i)})
        else $error("status read wrong");
    read_idle_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            !rd_i |=> rdata_o == 8'h00)
        else $error("read data left standing");
    unmapped_read_a:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            rd_i && addr_i != `RLC_CTRL_OFF && addr_i != `RLC_STAT_OFF
            |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // Scenarios that the bench should reach
    power_on_c:
        cover property (@(posedge ref_clk_i) disable iff (rst_i)
            $rose(ladder_power_enable_o));
    pin_drive_c:
        cover property (@(posedge ref_clk_i) disable iff (rst_i)
            ladder_pin_output_enable_o && port_f_direction_i == 1'b0);
    low_range_c:
        cover property (@(posedge ref_clk_i) disable iff (rst_i)
            tap_low_sel_o[15]);
    high_range_c:
        cover property (@(posedge ref_clk_i) disable iff (rst_i)
            tap_high_sel_o[0]);
    ext_source_c:
        cover property (@(posedge ref_clk_i) disable iff (rst_i)
            ladder_source_select_o && tap_low_sel_o != 16'h0000);
endmodule
`default_nettype wire

// *** test/rlc_top_test.sv ***
// Self-checking bench for the ladder control register and pin steering
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
module rlc_top_test;
    import rlc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dir = 1'b1;
    logic dat = 1'b0;
    logic [7:0] rdata;
    logic pwr, src, poe, doe, pin;
    logic [15:0] lo, hi;
    int fail_count = 0;
    int cmp_count = 0;
    // Free-running 50 MHz clock
    always #10 clk = ~clk;
    rlc_top uut (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .port_f_direction_i(dir), .port_f_data_i(dat),
        .ladder_power_enable_o(pwr), .ladder_source_select_o(src),
        .tap_low_sel_o(lo), .tap_high_sel_o(hi),
        .ladder_pin_output_enable_o(poe),
        .shared_reference_pin_oe_o(doe), .shared_reference_pin_o(pin));
    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp,
        input string name);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write strobe
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // One-cycle read strobe, data checked in the following cycle
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(16'(rdata), 16'(e), "rdata");
    endtask
    // Expected ladder outputs for a control value
    task chk_out(input logic [7:0] v);
        logic [15:0] t;
        t = 16'h0001 << v[3:0];
        check(16'(pwr), 16'(v[7]), "power");
        check(16'(poe), 16'(v[6]), "pin_oe");
        check(16'(doe), 16'(!v[6] && !dir), "drv_oe");
        check(lo, (v[7] && v[5]) ? t : 16'h0000, "low");
        check(hi, (v[7] && !v[5]) ? t : 16'h0000, "high");
        check(16'(src), 16'(v[7] & v[4]), "src");
        check(16'(pin), 16'(dat), "pin");
    endtask
    task final_report();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog, over five times the some 1,840 cycles the tests take
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_out(8'h00);
        rd_chk(`RLC_CTRL_OFF, `RLC_CTRL_RST);
        $display("test reset done");
        for (int i = 0; i < 256; i++)
        begin
            // Pin inputs change right on a rising edge
            @(posedge clk);
            dir <= i[1];
            dat <= i[0];
            wr_reg(`RLC_CTRL_OFF, 8'(i));
            chk_out(8'(i));
            rd_chk(`RLC_CTRL_OFF, 8'(i));
            rd_chk(`RLC_STAT_OFF, {6'h00, !i[6] && !i[1], i[0]});
        end
        $display("test all values done");
        wr_reg(`RLC_CTRL_OFF, 8'hB7);
        // Unmapped writes leave the register alone
        wr_reg(4'h2, 8'h00);
        wr_reg(4'hF, 8'h40);
        rd_chk(4'h7, 8'h00);
        repeat (20) @(posedge clk);
        #1;
        chk_out(8'hB7);
        rd_chk(`RLC_CTRL_OFF, 8'hB7);
        $display("test unmapped and hold done");
        // Reset in mid-run
        wr_reg(`RLC_CTRL_OFF, 8'hFF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_out(8'h00);
        rd_chk(`RLC_CTRL_OFF, 8'h00);
        $display("test mid reset done");
        final_report();
    end
endmodule
`default_nettype wire
